// >>> verilog/pmb_bar_bank.sv
// Operation
// - Bit 17 masks hot-swap notify pin
// - Bit 19 drives board LED, resets off
// - Bit 22 flags imminent board extraction
// - Bit 23 flags fresh board insertion
// - Function 1 five 32-bit window bases
// - Function 2 CPU base plus wide pairs
// - Wide low base: type fixed to configuration writes (CPU writes bits 3:0), writable top
// - Wide high half fully writable, resets zero
// - Function 5 wide SDRAM bank 2, 3 pairs
// - Function 6 wide device windows 0-2
// - Function 7 window 3, boot, CPU pairs
// - Plain base: low twelve bits read-only to configuration writes, CPU writes bits 3:0
`timescale 1ns/1ps
`default_nettype none
module pmb_bar_bank (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire pmb_pkg::pmb_req_s    pci_req,
    output var  pmb_pkg::pmb_rsp_s    pci_rsp,
    input  wire pmb_pkg::pmb_req_s    cpu_req,
    output var  pmb_pkg::pmb_rsp_s    cpu_rsp,
    input  wire logic                 extract_pin,
    input  wire logic                 insert_pin,
    output logic                      hotswap_notify_n,
    output logic                      front_led_ctl,
    output logic [pmb_pkg::NUM_BARS-1:0][31:0] bar_value
);

    // ==========================================================
    // Decode helpers
    function automatic logic [pmb_pkg::IDX_W:0] find_bar(
        input logic [2:0] f,
        input logic [7:0] o
    );
        logic [pmb_pkg::IDX_W:0] res;
        res = '0;
        for (int i = 0; i < pmb_pkg::NUM_BARS; i++) begin
            if (pmb_pkg::BAR_TABLE[i].func == f &&
                pmb_pkg::BAR_TABLE[i].offset == {o[7:2], 2'b00}) begin
                res = {1'b1, i[pmb_pkg::IDX_W-1:0]};
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic is_hotswap(
        input logic [2:0] f,
        input logic [7:0] o
    );
        return f == pmb_pkg::FN0 && {o[7:2], 2'b00} == pmb_pkg::OFF_HOTSWAP;
    endfunction

    // ==========================================================
    // Request decode
    logic [pmb_pkg::IDX_W:0]   pci_find;
    logic [pmb_pkg::IDX_W:0]   cpu_find;
    logic                      pci_hit;
    logic                      cpu_hit;
    logic [pmb_pkg::IDX_W-1:0] pci_idx;
    logic [pmb_pkg::IDX_W-1:0] cpu_idx;
    logic                      pci_wr;
    logic                      cpu_wr;
    logic                      pci_is_hs;
    logic                      cpu_is_hs;
    logic [31:0]               pci_m;
    logic [31:0]               cpu_m;

    assign pci_find  = find_bar(pci_req.func, pci_req.offset);
    assign cpu_find  = find_bar(cpu_req.func, cpu_req.offset);
    assign pci_hit   = pci_find[pmb_pkg::IDX_W];
    assign cpu_hit   = cpu_find[pmb_pkg::IDX_W];
    assign pci_idx   = pci_find[pmb_pkg::IDX_W-1:0];
    assign cpu_idx   = cpu_find[pmb_pkg::IDX_W-1:0];
    assign pci_wr    = pci_req.valid && pci_req.write;
    assign cpu_wr    = cpu_req.valid && cpu_req.write;
    assign pci_is_hs = is_hotswap(pci_req.func, pci_req.offset);
    assign cpu_is_hs = is_hotswap(cpu_req.func, cpu_req.offset);
    assign pci_m     = be_mask(pci_req.be);
    assign cpu_m     = be_mask(cpu_req.be);

    // ==========================================================
    // Base registers
    // CPU write lands after the configuration write, so it wins a same-cycle tie
    logic [31:0] next_bar [pmb_pkg::NUM_BARS];

    for (genvar g = 0; g < pmb_pkg::NUM_BARS; g++) begin : g_bar
        localparam logic [31:0] PCI_WM = pmb_pkg::BAR_TABLE[g].upper ?
                                         pmb_pkg::HI_WMASK : pmb_pkg::LO_PCI_WMASK;
        localparam logic [31:0] CPU_WM = pmb_pkg::BAR_TABLE[g].upper ?
                                         pmb_pkg::HI_WMASK : pmb_pkg::LO_CPU_WMASK;
        logic        pci_sel;
        logic        cpu_sel;
        logic [31:0] pm;
        logic [31:0] cm;
        logic [31:0] after_pci;

        assign pci_sel   = pci_wr && pci_hit && int'(pci_idx) == g;
        assign cpu_sel   = cpu_wr && cpu_hit && int'(cpu_idx) == g;
        assign pm        = pci_sel ? (pci_m & PCI_WM) : 32'h0000_0000;
        assign cm        = cpu_sel ? (cpu_m & CPU_WM) : 32'h0000_0000;
        assign after_pci = (bar_value[g] & ~pm) | (pci_req.wdata & pm);
        assign next_bar[g] = (after_pci & ~cm) | (cpu_req.wdata & cm);
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < pmb_pkg::NUM_BARS; i++) begin
            if (reset) begin
                bar_value[i] <= pmb_pkg::BAR_TABLE[i].rst;
            end else begin
                bar_value[i] <= next_bar[i];
            end
        end
    end

    // ==========================================================
    // Hot-swap pin synchronisers
    // Only the second and third stages feed the edge detector
    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] pin_last;
    logic       ext_rise;
    logic       ins_rise;

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta <= 2'h0;
            pin_sync <= 2'h0;
            pin_last <= 2'h0;
        end else begin
            pin_meta <= {insert_pin, extract_pin};
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end

    assign ext_rise = pin_sync[0] && !pin_last[0];
    assign ins_rise = pin_sync[1] && !pin_last[1];

    // ==========================================================
    // Hot-swap control and status
    logic        hs_mask;
    logic        hs_ext;
    logic        hs_ins;
    logic        pci_hs_wr;
    logic        cpu_hs_wr;
    logic        next_hs_mask;
    logic        next_led;
    logic        clr_ext;
    logic        clr_ins;
    logic        next_hs_ext;
    logic        next_hs_ins;
    logic        notify_req;
    logic [31:0] hs_word;

    assign pci_hs_wr = pci_wr && pci_is_hs;
    assign cpu_hs_wr = cpu_wr && cpu_is_hs;

    assign next_hs_mask = (cpu_hs_wr && cpu_m[pmb_pkg::HS_MASK_BIT]) ? cpu_req.wdata[pmb_pkg::HS_MASK_BIT] :
                          (pci_hs_wr && pci_m[pmb_pkg::HS_MASK_BIT]) ? pci_req.wdata[pmb_pkg::HS_MASK_BIT] :
                          hs_mask;
    assign next_led     = (cpu_hs_wr && cpu_m[pmb_pkg::HS_LED_BIT]) ? cpu_req.wdata[pmb_pkg::HS_LED_BIT] :
                          (pci_hs_wr && pci_m[pmb_pkg::HS_LED_BIT]) ? pci_req.wdata[pmb_pkg::HS_LED_BIT] :
                          front_led_ctl;

    // Status bits clear by writing one; a new edge in the same cycle wins
    assign clr_ext = (pci_hs_wr && pci_m[pmb_pkg::HS_EXT_BIT] && pci_req.wdata[pmb_pkg::HS_EXT_BIT]) ||
                     (cpu_hs_wr && cpu_m[pmb_pkg::HS_EXT_BIT] && cpu_req.wdata[pmb_pkg::HS_EXT_BIT]);
    assign clr_ins = (pci_hs_wr && pci_m[pmb_pkg::HS_INS_BIT] && pci_req.wdata[pmb_pkg::HS_INS_BIT]) ||
                     (cpu_hs_wr && cpu_m[pmb_pkg::HS_INS_BIT] && cpu_req.wdata[pmb_pkg::HS_INS_BIT]);
    assign next_hs_ext = ext_rise || (hs_ext && !clr_ext);
    assign next_hs_ins = ins_rise || (hs_ins && !clr_ins);

    // Notify follows the status one cycle late, the price of a flopped pin
    assign notify_req = (hs_ext || hs_ins) && !hs_mask;

    assign hs_word = pmb_pkg::HS_FIXED
                   | ({31'h0000_0000, hs_mask}       << pmb_pkg::HS_MASK_BIT)
                   | ({31'h0000_0000, front_led_ctl} << pmb_pkg::HS_LED_BIT)
                   | ({31'h0000_0000, hs_ext}        << pmb_pkg::HS_EXT_BIT)
                   | ({31'h0000_0000, hs_ins}        << pmb_pkg::HS_INS_BIT);

    always_ff @(posedge clk) begin
        if (reset) begin
            hs_mask          <= pmb_pkg::HS_MASK_RST;
            front_led_ctl    <= pmb_pkg::HS_LED_RST;
            hs_ext           <= 1'b0;
            hs_ins           <= 1'b0;
            hotswap_notify_n <= 1'b1;
        end else begin
            hs_mask          <= next_hs_mask;
            front_led_ctl    <= next_led;
            hs_ext           <= next_hs_ext;
            hs_ins           <= next_hs_ins;
            hotswap_notify_n <= !notify_req;
        end
    end

    // ==========================================================
    // Read path
    // Reads return the value before any write of the same cycle
    logic [31:0] pci_rword;
    logic [31:0] cpu_rword;

    assign pci_rword = pci_is_hs ? hs_word : (pci_hit ? bar_value[pci_idx] : 32'h0000_0000);
    assign cpu_rword = cpu_is_hs ? hs_word : (cpu_hit ? bar_value[cpu_idx] : 32'h0000_0000);

    always_ff @(posedge clk) begin
        if (reset) begin
            pci_rsp <= '0;
            cpu_rsp <= '0;
        end else begin
            pci_rsp.ack   <= pci_req.valid;
            pci_rsp.rdata <= (pci_req.valid && !pci_req.write) ? pci_rword : 32'h0000_0000;
            cpu_rsp.ack   <= cpu_req.valid;
            cpu_rsp.rdata <= (cpu_req.valid && !cpu_req.write) ? cpu_rword : 32'h0000_0000;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    logic [31:0] pci_sel_word;
    logic        all_at_reset;
    logic [pmb_pkg::NUM_BARS-1:0] at_reset_vec;
    logic [pmb_pkg::NUM_BARS-1:0] rsvd_ok_vec;

    assign pci_sel_word = pci_hit ? bar_value[pci_idx] : 32'h0000_0000;
    for (genvar k = 0; k < pmb_pkg::NUM_BARS; k++) begin : g_chk
        assign at_reset_vec[k] = bar_value[k] == pmb_pkg::BAR_TABLE[k].rst;
        assign rsvd_ok_vec[k]  = pmb_pkg::BAR_TABLE[k].upper || bar_value[k][11:4] == 8'h00;
    end
    assign all_at_reset = &at_reset_vec;

    a_notify_masked: assert property (hs_mask |=> hotswap_notify_n)
        else $error("notify asserted while masked");

    a_notify_open: assert property ((!hs_mask && (hs_ext || hs_ins)) |=> !hotswap_notify_n)
        else $error("notify missing while unmasked");

    a_led_write: assert property ((pci_hs_wr && pci_m[pmb_pkg::HS_LED_BIT] && !cpu_hs_wr)
        |=> front_led_ctl == $past(pci_req.wdata[pmb_pkg::HS_LED_BIT]))
        else $error("led does not follow written bit");

    a_extract_flag: assert property ($rose(pin_sync[0]) |=> hs_ext ##1 hs_ext || $past(clr_ext))
        else $error("extraction edge not flagged");

    a_insert_flag: assert property ($rose(pin_sync[1]) |=> hs_ins)
        else $error("insertion edge not flagged");

    a_reset_values: assert property ($fell(reset) |-> all_at_reset)
        else $error("base register reset value wrong");

    a_pci_ro_low: assert property ((pci_wr && pci_hit && !cpu_wr && !pmb_pkg::BAR_TABLE[pci_idx].upper)
        |=> bar_value[$past(pci_idx)][11:0] == $past(pci_sel_word[11:0]))
        else $error("configuration write changed read-only bits");

    a_pci_base_write: assert property ((pci_wr && pci_hit && !cpu_wr && pci_req.be == 4'hf)
        |=> bar_value[$past(pci_idx)][31:12] == $past(pci_req.wdata[31:12]))
        else $error("configuration write lost base bits");

    a_cpu_low_write: assert property ((cpu_wr && cpu_hit && cpu_req.be[0])
        |=> bar_value[$past(cpu_idx)][3:0] == $past(cpu_req.wdata[3:0]))
        else $error("cpu write lost low bits");

    a_rsp_timing: assert property (pci_req.valid
        |=> pci_rsp.ack && !($past(pci_req.write) && pci_rsp.rdata != 32'h0000_0000))
        else $error("configuration answer late or write data echoed");

    a_cpu_rsp_timing: assert property (cpu_req.valid
        |=> cpu_rsp.ack && !($past(cpu_req.write) && cpu_rsp.rdata != 32'h0000_0000))
        else $error("cpu answer late or write data echoed");

    a_reserved_zero: assert property (&rsvd_ok_vec)
        else $error("reserved base bits not zero");

    a_ext_clear: assert property ((hs_ext && clr_ext && !ext_rise) |=> !hs_ext)
        else $error("extraction flag not cleared");

    a_ins_clear: assert property ((hs_ins && clr_ins && !ins_rise) |=> !hs_ins)
        else $error("insertion flag not cleared");

    a_led_hold: assert property (!(pci_hs_wr || cpu_hs_wr) |=> $stable(front_led_ctl))
        else $error("led changed without a write");

    a_mask_hold: assert property (!(pci_hs_wr || cpu_hs_wr) |=> $stable(hs_mask))
        else $error("notify mask changed without a write");

    a_cpu_wins_tie: assert property ((pci_wr && cpu_wr && pci_hit && cpu_hit && pci_idx == cpu_idx
        && cpu_req.be == 4'hf) |=> bar_value[$past(cpu_idx)][31:12] == $past(cpu_req.wdata[31:12]))
        else $error("cpu write lost same-cycle tie");

    a_unmapped_read: assert property ((pci_req.valid && !pci_req.write && !pci_hit && !pci_is_hs)
        |=> pci_rsp.rdata == 32'h0000_0000)
        else $error("unmapped read returned data");

    c_notify_seen: cover property (!hs_mask ##1 hs_ext ##1 !hotswap_notify_n);
    c_base_written: cover property (pci_wr && pci_hit && pci_req.be == 4'hf);
    c_both_write: cover property (pci_wr && cpu_wr && pci_hit && cpu_hit && pci_idx == cpu_idx);
    c_status_clear: cover property (hs_ins && clr_ins);
    c_cpu_hs_read: cover property (cpu_req.valid && !cpu_req.write && cpu_is_hs);

endmodule // pmb_bar_bank
`default_nettype wire

// >>> verilog/pmb_pkg.sv
`default_nettype none
package pmb_pkg;

    // ==========================================================
    // Geometry
    localparam int NUM_BARS = 26;
    localparam int IDX_W    = 5;

    // ==========================================================
    // Configuration offsets and function numbers
    localparam logic [7:0] OFF_BAR0    = 8'h10;
    localparam logic [7:0] OFF_BAR1    = 8'h14;
    localparam logic [7:0] OFF_BAR2    = 8'h18;
    localparam logic [7:0] OFF_BAR3    = 8'h1c;
    localparam logic [7:0] OFF_BAR4    = 8'h20;
    localparam logic [7:0] OFF_BAR5    = 8'h24;
    localparam logic [7:0] OFF_HOTSWAP = 8'h60;
    localparam logic [2:0] FN0         = 3'h0;
    localparam logic [2:0] FN1         = 3'h1;
    localparam logic [2:0] FN2         = 3'h2;
    localparam logic [2:0] FN5         = 3'h5;
    localparam logic [2:0] FN6         = 3'h6;
    localparam logic [2:0] FN7         = 3'h7;

    // ==========================================================
    // Hot-swap register layout
    localparam int          HS_MASK_BIT = 17;
    localparam int          HS_LED_BIT  = 19;
    localparam int          HS_EXT_BIT  = 22;
    localparam int          HS_INS_BIT  = 23;
    localparam logic [31:0] HS_FIXED    = 32'h0000_0006;
    localparam logic        HS_MASK_RST = 1'b0;
    localparam logic        HS_LED_RST  = 1'b0;

    // ==========================================================
    // Write masks of base registers
    localparam logic [31:0] LO_PCI_WMASK = 32'hffff_f000;
    localparam logic [31:0] LO_CPU_WMASK = 32'hffff_f00f;
    localparam logic [31:0] HI_WMASK     = 32'hffff_ffff;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [2:0]  func;
        logic [7:0]  offset;
        logic [3:0]  be;
        logic [31:0] wdata;
    } pmb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
    } pmb_rsp_s;

    typedef struct packed {
        logic [2:0]  func;
        logic [7:0]  offset;
        logic        upper;
        logic [31:0] rst;
    } pmb_bar_entry_s;

    // ==========================================================
    // Base register map
    localparam pmb_bar_entry_s BAR_TABLE [NUM_BARS] = '{
        '{FN1, OFF_BAR0, 1'b0, 32'h1c00_0000},
        '{FN1, OFF_BAR1, 1'b0, 32'h1c80_0000},
        '{FN1, OFF_BAR2, 1'b0, 32'h1d00_0000},
        '{FN1, OFF_BAR3, 1'b0, 32'hff00_0000},
        '{FN1, OFF_BAR4, 1'b0, 32'hff80_0000},
        '{FN2, OFF_BAR0, 1'b0, 32'h0000_000c},
        '{FN2, OFF_BAR1, 1'b1, 32'h0000_0000},
        '{FN2, OFF_BAR2, 1'b0, 32'h0080_000c},
        '{FN2, OFF_BAR3, 1'b0, 32'h4000_0008},
        '{FN2, OFF_BAR4, 1'b1, 32'h0000_0000},
        '{FN5, OFF_BAR0, 1'b0, 32'h0100_000c},
        '{FN5, OFF_BAR1, 1'b1, 32'h0000_0000},
        '{FN5, OFF_BAR2, 1'b0, 32'h0180_000c},
        '{FN5, OFF_BAR3, 1'b1, 32'h0000_0000},
        '{FN6, OFF_BAR0, 1'b0, 32'h1c00_0004},
        '{FN6, OFF_BAR1, 1'b1, 32'h0000_0000},
        '{FN6, OFF_BAR2, 1'b0, 32'h1c80_0004},
        '{FN6, OFF_BAR3, 1'b1, 32'h0000_0000},
        '{FN6, OFF_BAR4, 1'b0, 32'h1d00_0004},
        '{FN6, OFF_BAR5, 1'b1, 32'h0000_0000},
        '{FN7, OFF_BAR0, 1'b0, 32'hff00_0004},
        '{FN7, OFF_BAR1, 1'b1, 32'h0000_0000},
        '{FN7, OFF_BAR2, 1'b0, 32'hff80_0004},
        '{FN7, OFF_BAR3, 1'b1, 32'h0000_0000},
        '{FN7, OFF_BAR4, 1'b0, 32'h4200_000c},
        '{FN7, OFF_BAR5, 1'b1, 32'h0000_0000}
    };

endpackage
`default_nettype wire

// >>> tb/pmb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmb_host_model (
    input  wire logic              clk,
    output var  pmb_pkg::pmb_req_s req,
    input  wire pmb_pkg::pmb_rsp_s rsp
);
    // ==========================================================
    // Configuration cycle issuer
    initial begin
        req = '0;
    end

    task automatic access(input logic wr, input logic [2:0] fn, input logic [7:0] off, input logic [3:0] be,
                          input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        @(posedge clk);
        #1;
        req = '{valid: 1'b1, write: wr, func: fn, offset: off, be: be, wdata: wd};
        @(posedge clk);
        #1;
        // Inverted leftovers, so a late sample of stale fields shows up
        req = ~req;
        ok = rsp.ack;
        rd = rsp.rdata;
    endtask
endmodule // pmb_host_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                               clk         = 1'b0;
    logic                               reset       = 1'b1;
    logic                               extract_pin = 1'b0;
    logic                               insert_pin  = 1'b0;
    pmb_pkg::pmb_req_s                  pci_req;
    pmb_pkg::pmb_req_s                  cpu_req;
    pmb_pkg::pmb_rsp_s                  pci_rsp;
    pmb_pkg::pmb_rsp_s                  cpu_rsp;
    logic                               hotswap_notify_n;
    logic                               front_led_ctl;
    logic [pmb_pkg::NUM_BARS-1:0][31:0] bar_value;
    int                                 num_errors = 0;
    int                                 checked    = 0;
    int                                 cycles     = 0;
    logic [31:0]                        shadow [pmb_pkg::NUM_BARS];
    logic [31:0]                        rd, rd2, d, d2, hs;
    logic [3:0]                         b;
    logic                               ok, ok2;
    localparam logic [25:0] UPPER = 26'h2aa_aa40;
    localparam logic [31:0] RST [26] = '{32'h1c000000, 32'h1c800000, 32'h1d000000, 32'hff000000, 32'hff800000,
        32'h0000000c, 32'h0, 32'h0080000c, 32'h40000008, 32'h0, 32'h0100000c, 32'h0, 32'h0180000c, 32'h0,
        32'h1c000004, 32'h0, 32'h1c800004, 32'h0, 32'h1d000004, 32'h0,
        32'hff000004, 32'h0, 32'hff800004, 32'h0, 32'h4200000c, 32'h0};

    pmb_bar_bank dut_u (.clk(clk), .reset(reset), .pci_req(pci_req), .pci_rsp(pci_rsp), .cpu_req(cpu_req),
        .cpu_rsp(cpu_rsp), .extract_pin(extract_pin), .insert_pin(insert_pin),
        .hotswap_notify_n(hotswap_notify_n), .front_led_ctl(front_led_ctl), .bar_value(bar_value));
    pmb_host_model host_u (.clk(clk), .req(pci_req), .rsp(pci_rsp));
    pmb_host_model cpu_u (.clk(clk), .req(cpu_req), .rsp(cpu_rsp));

    // ==========================================================
    // Clock, timeout, reporting
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Expectations
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] v, input logic [3:0] be,
                                          input logic [31:0] wm);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
        return (old & ~m) | (v & m);
    endfunction

    function automatic logic [31:0] wmask(input int i, input logic from_cpu);
        if (UPPER[i]) begin
            return 32'hffffffff;
        end
        return from_cpu ? 32'hfffff00f : 32'hfffff000;
    endfunction

    task automatic acc(input logic on_cpu, input logic wr, input logic [2:0] fn, input logic [7:0] off,
                       input logic [3:0] be, input logic [31:0] wd);
        if (on_cpu) begin
            cpu_u.access(wr, fn, off, be, wd, rd, ok);
        end else begin
            host_u.access(wr, fn, off, be, wd, rd, ok);
        end
        check("ack", {31'h0, ok}, 32'h1);
        if (wr) begin
            check("write rdata", rd, 32'h0);
        end
    endtask

    task automatic bar_rd(input logic on_cpu, input int i);
        acc(on_cpu, 1'b0, pmb_pkg::BAR_TABLE[i].func, pmb_pkg::BAR_TABLE[i].offset, 4'hf, 32'h0);
        check("bar readback", rd, shadow[i]);
    endtask

    task automatic check_all();
        for (int i = 0; i < pmb_pkg::NUM_BARS; i++) begin
            check("bar value", bar_value[i], shadow[i]);
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'h4a4d));
        repeat (20) @(posedge clk);
        #1;
        reset = 1'b0;
        shadow = RST;
        check_all();
        for (int i = 0; i < pmb_pkg::NUM_BARS; i++) begin
            bar_rd(1'b0, i);
        end
        acc(1'b0, 1'b0, pmb_pkg::FN0, pmb_pkg::OFF_HOTSWAP, 4'hf, 32'h0);
        check("hotswap reset", rd, 32'h6);
        check("led reset", {31'h0, front_led_ctl}, 32'h0);
        $display("test reset values done");
        // All-ones first, so read-only bits are hit with set values
        for (int r = 0; r < 4; r++) begin
            for (int i = 0; i < pmb_pkg::NUM_BARS; i++) begin
                d = (r == 0) ? 32'hffffffff : $urandom();
                b = (r < 2) ? 4'hf : 4'($urandom());
                acc(r[0], 1'b1, pmb_pkg::BAR_TABLE[i].func, pmb_pkg::BAR_TABLE[i].offset, b, d);
                shadow[i] = merge(shadow[i], d, b, wmask(i, r[0]));
                check("bar written", bar_value[i], shadow[i]);
                bar_rd(~r[0], i);
            end
        end
        acc(1'b0, 1'b1, 3'h3, 8'h10, 4'hf, $urandom());
        acc(1'b1, 1'b0, 3'h3, 8'h10, 4'hf, 32'h0);
        check("unmapped read", rd, 32'h0);
        acc(1'b0, 1'b0, pmb_pkg::FN1, 8'h24, 4'hf, 32'h0);
        check("unmapped read", rd, 32'h0);
        check_all();
        $display("test random writes done");
        d = $urandom();
        d2 = $urandom();
        fork
            host_u.access(1'b1, pmb_pkg::FN6, 8'h10, 4'hf, d, rd, ok);
            cpu_u.access(1'b1, pmb_pkg::FN6, 8'h10, 4'hf, d2, rd2, ok2);
        join
        shadow[14] = merge(merge(shadow[14], d, 4'hf, wmask(14, 1'b0)), d2, 4'hf, wmask(14, 1'b1));
        check_all();
        $display("test same cycle writes done");
        acc(1'b0, 1'b1, pmb_pkg::FN0, pmb_pkg::OFF_HOTSWAP, 4'h4, 32'h00080000);
        check("led on", {31'h0, front_led_ctl}, 32'h1);
        for (int p = 0; p < 2; p++) begin
            hs = (p == 0) ? 32'h00800000 : 32'h00400000;
            insert_pin = (p == 0);
            extract_pin = (p == 1);
            repeat (5) @(posedge clk);
            #1;
            check("notify low", {31'h0, hotswap_notify_n}, 32'h0);
            acc(1'b0, 1'b0, pmb_pkg::FN0, pmb_pkg::OFF_HOTSWAP, 4'hf, 32'h0);
            check("hotswap flag", rd, 32'h00080006 | hs);
            acc(1'b0, 1'b1, pmb_pkg::FN0, pmb_pkg::OFF_HOTSWAP, 4'h4, 32'h000a0000);
            repeat (2) @(posedge clk);
            #1;
            check("notify masked", {31'h0, hotswap_notify_n}, 32'h1);
            acc(1'b1, 1'b1, pmb_pkg::FN0, pmb_pkg::OFF_HOTSWAP, 4'h4, 32'h000a0000 | hs);
            acc(1'b0, 1'b0, pmb_pkg::FN0, pmb_pkg::OFF_HOTSWAP, 4'hf, 32'h0);
            check("hotswap cleared", rd, 32'h000a0006);
            acc(1'b0, 1'b1, pmb_pkg::FN0, pmb_pkg::OFF_HOTSWAP, 4'h4, 32'h00080000);
            repeat (2) @(posedge clk);
            #1;
            check("notify idle", {31'h0, hotswap_notify_n}, 32'h1);
            insert_pin = 1'b0;
            extract_pin = 1'b0;
        end
        $display("test hot swap done");
        // Mask left set, so the reset has something to clear
        acc(1'b0, 1'b1, pmb_pkg::FN0, pmb_pkg::OFF_HOTSWAP, 4'h4, 32'h000a0000);
        reset = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        shadow = RST;
        check_all();
        check("led after reset", {31'h0, front_led_ctl}, 32'h0);
        check("notify after reset", {31'h0, hotswap_notify_n}, 32'h1);
        acc(1'b1, 1'b0, pmb_pkg::FN0, pmb_pkg::OFF_HOTSWAP | 8'h03, 4'hf, 32'h0);
        check("hotswap after reset", rd, 32'h6);
        $display("test second reset done");
        test_done();
    end
endmodule // tb
`default_nettype wire
